// >>> rtl/tlic_pkg.sv
// constants, types and field layouts of the two-level interrupt controller
// How it works
// - Fifteen request sources: two pins, two timers, eight capture-timer events, ADC, CAN, UART.
// - Two priority levels with nesting of a high routine over a low one.
// - No request is accepted while the CAN DMA transfer runs.
// - Every source has its own vector, presented when the source is taken.
// - Each source has one enable bit; a disabled request is never accepted.
// - Each source has one priority bit; zero low level, one high level.
// - Bit 7 of the first enable register gates all sources globally.
// - First enable bits 6..0: ADC, CAN, UART, timer 1, pin 1, timer 0, pin 0.
// - Second enable: bit 7 overflow, bits 6..4 compares, bits 3..0 captures.
// - First priority bit 7 unused; bits 6..0 in first enable register order.
// - External pins are level or falling-edge triggered, active low.
// - Capture timer gives eight separately enabled and prioritised requests.
// - Capture pins act as edge interrupts; they cannot wake the idle state.
// - Request-to-service latency stays within 2.25 to 7.5 us.
// - With both levels pending, the high-level request is taken.
// - Equal-level requests are taken in the fixed rank order.
// - Low routines yield only to high requests; high routines are never preempted.
// - Vectors start at 0003h and step by eight in source table order.
package tlic_pkg;

  // register offsets on the 8-bit register port
  localparam logic [7:0] ADDR_SRC_EN_LO   = 8'ha8;
  localparam logic [7:0] ADDR_PRIO_LO     = 8'hb8;
  localparam logic [7:0] ADDR_SRC_EN_HI   = 8'he8;
  localparam logic [7:0] ADDR_PRIO_HI     = 8'hf8;
  localparam logic [7:0] ADDR_TRIG_MODE   = 8'hd8;
  localparam logic [7:0] ADDR_CAP_EDGE    = 8'hd9;
  localparam logic [7:0] ADDR_PEND_LO     = 8'hda;
  localparam logic [7:0] ADDR_PEND_HI     = 8'hdb;
  localparam logic [7:0] ADDR_SVC_STAT    = 8'hdc;

  // reset values and field positions
  localparam logic [7:0] REG_RESET        = 8'h00;
  localparam int         GLOBAL_IRQ_GATE  = 7;
  localparam logic [7:0] PRIO_LO_MASK     = 8'h7f;

  // source indices in vector table order
  localparam logic [3:0] SRC_PIN0   = 4'h0;
  localparam logic [3:0] SRC_TMR0   = 4'h1;
  localparam logic [3:0] SRC_PIN1   = 4'h2;
  localparam logic [3:0] SRC_TMR1   = 4'h3;
  localparam logic [3:0] SRC_UART   = 4'h4;
  localparam logic [3:0] SRC_CAN    = 4'h5;
  localparam logic [3:0] SRC_CAP0   = 4'h6;
  localparam logic [3:0] SRC_ADC    = 4'ha;
  localparam logic [3:0] SRC_CMP0   = 4'hb;
  localparam logic [3:0] SRC_WRAP   = 4'he;
  localparam int         NUM_SRC    = 15;

  // rank order, first served in the low nibble
  localparam logic [59:0] RANK_ORDER = {4'he, 4'h9, 4'h4, 4'hd, 4'h8, 4'h3, 4'hc, 4'h7,
                                        4'h2, 4'hb, 4'h6, 4'h1, 4'ha, 4'h5, 4'h0};

  // vector layout
  localparam logic [15:0] VECTOR_BASE = 16'h0003;

  // capture pin edge selection codes
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;

  // latency bounds in ns and in clock cycles at 100 MHz
  localparam int CLK_PERIOD_NS = 10;
  localparam int LAT_MIN_NS    = 2250;
  localparam int LAT_MAX_NS    = 7500;
  localparam int LAT_MIN_CYC   = (LAT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LAT_MAX_CYC   = LAT_MAX_NS / CLK_PERIOD_NS;

  // service nesting state
  typedef enum logic [1:0] {
    SVC_IDLE     = 2'b00,
    SVC_LOW      = 2'b01,
    SVC_HIGH     = 2'b10,
    SVC_HIGH_LOW = 2'b11
  } tlic_svc_type;

endpackage : tlic_pkg

// >>> rtl/tlic_core.sv
// two-level nested interrupt controller with vector hand-off to the cpu core
`timescale 1ns/100ps
`default_nettype none
module tlic_core (
  input  wire logic        i_clk,          // cpu clock
  input  wire logic        i_rst_n,        // synchronous reset, active low
  input  wire logic [7:0]  i_addr,         // register address
  input  wire logic [7:0]  i_wdata,        // register write data
  input  wire logic        i_wr,           // register write strobe
  input  wire logic        i_rd,           // register read strobe
  output logic      [7:0]  o_rdata,        // read data, cycle after strobe
  input  wire logic        i_ext_req0_n,   // external request pin zero
  input  wire logic        i_ext_req1_n,   // external request pin one
  input  wire logic        i_timer0,       // timer 0 overflow flag
  input  wire logic        i_timer1,       // timer 1 overflow flag
  input  wire logic        i_uart,         // uart request flag
  input  wire logic        i_can,          // can controller request flag
  input  wire logic        i_adc,          // adc conversion done flag
  input  wire logic [3:0]  i_cap_evt,      // capture event flags 3..0
  input  wire logic [3:0]  i_cap_pin,      // capture input pins 3..0
  input  wire logic [2:0]  i_cmp_evt,      // compare event flags 2..0
  input  wire logic        i_wrap_evt,     // capture timer overflow flag
  input  wire logic        i_idle,         // cpu idle, capture timer stopped
  input  wire logic        i_can_dma,      // can dma transfer in progress
  input  wire logic        i_ack,          // cpu takes the offered vector
  input  wire logic        i_reti,         // cpu ends a service routine
  output logic             o_irq,          // vector offered to the cpu
  output logic      [15:0] o_vector,       // program address of the routine
  output logic      [3:0]  o_src,          // index of the offered source
  output logic             o_level         // level of the offered source
);
  import tlic_pkg::*;

  typedef struct packed {
    logic [7:0]   en_lo;      // source_enable_low
    logic [7:0]   en_hi;      // source_enable_high
    logic [7:0]   pr_lo;      // priority_select_low
    logic [7:0]   pr_hi;      // priority_select_high
    logic [7:0]   trig;       // pin trigger modes
    logic [7:0]   cap_edge;   // capture pin edge selection
    logic [1:0]   ext_prev;   // previous pin levels
    logic [1:0]   ext_flag;   // latched pin falling edges
    logic [3:0]   cap_prev;   // previous capture pin levels
    logic [3:0]   cap_flag;   // latched capture pin edges
    tlic_svc_type svc;        // nesting state
    logic         irq;
    logic [15:0]  vector;
    logic [3:0]   src;
    logic         level;
    logic [7:0]   rdata;
  } tlic_state_type;

  tlic_state_type s_q;
  tlic_state_type s_d;

  // spread two 8-bit registers over the fifteen sources in table order
  function automatic logic [14:0] tlic_map(input logic [7:0] lo, input logic [7:0] hi);
    tlic_map = {hi[7], hi[6:4], lo[6], hi[3:0], lo[5:0]};
  endfunction : tlic_map

  // first requesting source in the fixed rank order
  function automatic logic [3:0] tlic_pick(input logic [14:0] m);
    logic [3:0] idx;
    logic       hit;
    tlic_pick = 4'h0;
    hit       = 1'b0;
    for (int k = 0; k < NUM_SRC; k++) begin
      idx = RANK_ORDER[4*k +: 4];
      if (!hit && m[idx]) begin
        tlic_pick = idx;
        hit       = 1'b1;
      end
    end
  endfunction : tlic_pick

  logic [14:0] pend;
  logic [14:0] en_vec;
  logic [14:0] lvl_vec;
  logic [14:0] lvl_ok;
  logic [14:0] elig;
  logic [14:0] elig_hi;
  logic [3:0]  pick;
  logic        ack;
  logic [1:0]  ext_pin;
  logic [1:0]  ext_fall;
  logic [3:0]  cap_hit;

  // pending requests, enables and levels per source
  always_comb begin
    ext_pin  = {i_ext_req1_n, i_ext_req0_n};
    ext_fall = s_q.ext_prev & ~ext_pin;
    for (int n = 0; n < 4; n++) begin
      cap_hit[n] = !i_idle &&
                   ((s_q.cap_edge[2*n +: 2] & EDGE_RISE) != 2'h0 && !s_q.cap_prev[n]
                     && i_cap_pin[n] ||
                    (s_q.cap_edge[2*n +: 2] & EDGE_FALL) != 2'h0 && s_q.cap_prev[n]
                     && !i_cap_pin[n]);
    end
    pend = {i_wrap_evt, i_cmp_evt, i_adc, i_cap_evt | s_q.cap_flag,
            i_can, i_uart, i_timer1,
            s_q.trig[1] ? s_q.ext_flag[1] : !ext_pin[1],
            i_timer0,
            s_q.trig[0] ? s_q.ext_flag[0] : !ext_pin[0]};
    en_vec  = tlic_map(s_q.en_lo, s_q.en_hi);
    lvl_vec = tlic_map(s_q.pr_lo, s_q.pr_hi);
  end

  // eligibility under the nesting state and the fixed ranking
  always_comb begin
    case (s_q.svc)
      SVC_IDLE:     lvl_ok = '1;
      SVC_LOW:      lvl_ok = lvl_vec;
      SVC_HIGH:     lvl_ok = '0;
      SVC_HIGH_LOW: lvl_ok = '0;
      default:      lvl_ok = '0;
    endcase
    elig    = pend & en_vec & lvl_ok & {NUM_SRC{s_q.en_lo[GLOBAL_IRQ_GATE]}};
    elig_hi = elig & lvl_vec;
    pick    = (elig_hi != '0) ? tlic_pick(elig_hi) : tlic_pick(elig);
    ack     = i_ack && s_q.irq;
  end

  // next state of every register
  always_comb begin
    s_d = s_q;

    // nesting: completion first, then a new acknowledge
    if (i_reti) begin
      case (s_q.svc)
        SVC_HIGH_LOW: s_d.svc = SVC_LOW;
        SVC_HIGH:     s_d.svc = SVC_IDLE;
        SVC_LOW:      s_d.svc = SVC_IDLE;
        default:      s_d.svc = SVC_IDLE;
      endcase
    end
    if (ack) begin
      if (s_q.level) begin
        s_d.svc = (s_d.svc == SVC_LOW) ? SVC_HIGH_LOW : SVC_HIGH;
      end else begin
        s_d.svc = SVC_LOW;
      end
    end

    // edge flags: a new edge wins over the clear by acknowledge
    s_d.ext_prev = ext_pin;
    s_d.cap_prev = i_cap_pin;
    for (int n = 0; n < 2; n++) begin
      s_d.ext_flag[n] = s_q.trig[n] &&
                        (ext_fall[n] || s_q.ext_flag[n] &&
                         !(ack && s_q.src == (n == 0 ? SRC_PIN0 : SRC_PIN1)));
    end
    for (int n = 0; n < 4; n++) begin
      s_d.cap_flag[n] = cap_hit[n] ||
                        s_q.cap_flag[n] && !(ack && s_q.src == SRC_CAP0 + 4'(n));
    end

    // register writes
    if (i_wr) begin
      case (i_addr)
        ADDR_SRC_EN_LO: s_d.en_lo    = i_wdata;
        ADDR_SRC_EN_HI: s_d.en_hi    = i_wdata;
        ADDR_PRIO_LO:   s_d.pr_lo    = i_wdata & PRIO_LO_MASK;
        ADDR_PRIO_HI:   s_d.pr_hi    = i_wdata;
        ADDR_TRIG_MODE: s_d.trig     = {6'h00, i_wdata[1:0]};
        ADDR_CAP_EDGE:  s_d.cap_edge = i_wdata;
        default:        s_d.trig     = s_q.trig;
      endcase
    end

    // register reads, answered in the next cycle
    s_d.rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        ADDR_SRC_EN_LO: s_d.rdata = s_q.en_lo;
        ADDR_SRC_EN_HI: s_d.rdata = s_q.en_hi;
        ADDR_PRIO_LO:   s_d.rdata = s_q.pr_lo;
        ADDR_PRIO_HI:   s_d.rdata = s_q.pr_hi;
        ADDR_TRIG_MODE: s_d.rdata = s_q.trig;
        ADDR_CAP_EDGE:  s_d.rdata = s_q.cap_edge;
        ADDR_PEND_LO:   s_d.rdata = pend[7:0];
        ADDR_PEND_HI:   s_d.rdata = {1'b0, pend[14:8]};
        ADDR_SVC_STAT:  s_d.rdata = {5'h00, i_can_dma, s_q.svc};
        default:        s_d.rdata = 8'h00;
      endcase
    end

    // offer one vector per cycle, withdrawn during dma and on acknowledge
    s_d.irq    = (elig != '0) && !i_can_dma && !ack;
    s_d.src    = pick;
    s_d.level  = lvl_vec[pick];
    s_d.vector = VECTOR_BASE + {9'h000, pick, 3'h0};
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_q          <= '0;
      s_q.en_lo    <= REG_RESET;
      s_q.ext_prev <= 2'h3;
      s_q.svc      <= SVC_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata  = s_q.rdata;
  assign o_irq    = s_q.irq;
  assign o_vector = s_q.vector;
  assign o_src    = s_q.src;
  assign o_level  = s_q.level;

  // helper copies of the inputs to the last decision, and a count of cycles an eligible request waits unoffered
  logic [14:0] en_p_q;
  logic [14:0] lvl_p_q;
  logic [14:0] elig_p_q;
  logic [9:0]  wait_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      en_p_q   <= '0;
      lvl_p_q  <= '0;
      elig_p_q <= '0;
      wait_q   <= '0;
    end else begin
      en_p_q   <= en_vec;
      lvl_p_q  <= lvl_vec;
      elig_p_q <= elig;
      wait_q   <= (elig != '0 && !o_irq) ? wait_q + 10'h001 : 10'h000;
    end
  end

  AST_DMA_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_can_dma |=> !o_irq)
    else $error("vector offered during can dma");

  AST_GLOBAL_GATE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !s_q.en_lo[GLOBAL_IRQ_GATE] |=> !o_irq)
    else $error("vector offered with global gate off");

  AST_VECTOR_MAP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_irq |-> o_vector == VECTOR_BASE + {9'h000, o_src, 3'h0} && o_src <= SRC_WRAP)
    else $error("vector does not match source");

  AST_ENABLED_ONLY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_irq |-> en_p_q[o_src] && elig_p_q[o_src])
    else $error("disabled source offered");

  AST_HIGH_FIRST: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_irq && (elig_p_q & lvl_p_q) != '0 |-> lvl_p_q[o_src] && o_level)
    else $error("low source offered over high one");

  AST_HIGH_NO_PREEMPT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_q.svc[1] && !i_reti |=> !o_irq)
    else $error("high routine preempted");

  AST_LOW_YIELDS_HIGH: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_q.svc == SVC_LOW && !i_reti && !ack |=> !o_irq || o_level)
    else $error("low routine preempted by low request");

  AST_NEST_HIGH: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ack && o_level && !i_reti |=> s_q.svc[1] ##1 !o_irq)
    else $error("high acknowledge did not raise level");

  AST_OFFER_NEXT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    elig != '0 && !i_can_dma && !ack |=> o_irq)
    else $error("eligible request not offered");

  AST_LATENCY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wait_q < 10'(LAT_MAX_CYC))
    else $error("request waited past latency bound");

  AST_PIN_EDGE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_q.trig[0] && $fell(i_ext_req0_n) |=> s_q.ext_flag[0])
    else $error("falling edge on pin zero lost");

endmodule : tlic_core
`default_nettype wire

// >>> sim/tlic_cpu_model.sv
// cpu core model that takes offered vectors and ends service routines
`timescale 1ns/100ps
`default_nettype none
module tlic_cpu_model (
  input  wire logic       i_clk,   // cpu clock
  input  wire logic       i_rst_n, // synchronous reset, active low
  input  wire logic       i_irq,   // vector offered
  input  wire logic [3:0] i_src,   // offered source index
  input  wire logic       i_take,  // bench lets the core take vectors
  input  wire logic       i_done,  // bench ends the current routine
  output logic            o_ack,   // take pulse
  output logic            o_reti,  // routine end pulse
  output logic [3:0]      o_last,  // last source taken
  output logic [7:0]      o_taken  // count of vectors taken
);
  // take a standing offer with one pulse, never twice in a row
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_ack   <= 1'b0;
      o_reti  <= 1'b0;
      o_last  <= 4'h0;
      o_taken <= 8'h00;
    end else begin
      o_ack  <= i_take && i_irq && !o_ack;
      o_reti <= i_done;
      if (o_ack && i_irq) begin
        o_last  <= i_src;
        o_taken <= o_taken + 8'h01;
      end
    end
  end
endmodule : tlic_cpu_model
`default_nettype wire

// >>> sim/two_level_interrupt_controller_test.sv
// self-checking bench of the two-level interrupt controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module two_level_interrupt_controller_test;
  import tlic_pkg::*;
  logic i_clk, i_rst_n, i_wr, i_rd, i_p0_n, i_p1_n, i_t0, i_t1, i_uart, i_can, i_adc;
  logic i_wrap, i_idle, i_dma, ack, reti, take, done, o_irq, o_level;
  logic [7:0] i_addr, i_wdata, o_rdata, taken, rv;
  logic [3:0] i_cap, i_cpin, o_src, last;
  logic [2:0] i_cmp;
  logic [15:0] o_vector;
  int n_fail, checked;
  int rank[15] = '{0, 5, 10, 1, 6, 11, 2, 7, 12, 3, 8, 13, 4, 9, 14};

  tlic_core dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_req0_n(i_p0_n), .i_ext_req1_n(i_p1_n),
    .i_timer0(i_t0), .i_timer1(i_t1), .i_uart(i_uart), .i_can(i_can), .i_adc(i_adc),
    .i_cap_evt(i_cap), .i_cap_pin(i_cpin), .i_cmp_evt(i_cmp), .i_wrap_evt(i_wrap),
    .i_idle(i_idle), .i_can_dma(i_dma), .i_ack(ack), .i_reti(reti), .o_irq(o_irq),
    .o_vector(o_vector), .o_src(o_src), .o_level(o_level));
  tlic_cpu_model cpu (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_irq(o_irq), .i_src(o_src),
    .i_take(take), .i_done(done), .o_ack(ack), .o_reti(reti), .o_last(last), .o_taken(taken));

  // clock of 10 ns
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd
  // drive the fifteen requests in vector table order
  task automatic put(input logic [14:0] s);
    @(posedge i_clk);
    i_p0_n <= ~s[0]; i_t0 <= s[1]; i_p1_n <= ~s[2]; i_t1 <= s[3]; i_uart <= s[4];
    i_can <= s[5]; i_cap <= s[9:6]; i_adc <= s[10]; i_cmp <= s[13:11]; i_wrap <= s[14];
  endtask : put
  task automatic wait_irq(input int src);
    int k;
    for (k = 0; k < 20 && o_irq !== 1'b1; k++) cyc(1);
    `CHK(o_src, src[3:0])
  endtask : wait_irq
  task automatic take_one(input int src);
    logic [7:0] t0;
    int k;
    // let the core take one vector, changing the request only on a rising edge
    @(posedge i_clk) take <= 1'b1;
    t0 = taken;
    for (k = 0; k < 20 && taken === t0; k++) cyc(1);
    @(posedge i_clk) take <= 1'b0;
    `CHK(last, src[3:0])
  endtask : take_one
  task automatic end_svc(input logic [7:0] st);
    @(posedge i_clk);
    done <= 1'b1;
    @(posedge i_clk);
    done <= 1'b0;
    cyc(2);
    rd(ADDR_SVC_STAT, rv);
    `CHK(rv[1:0], st[1:0])
  endtask : end_svc
  task automatic final_report;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report

  // watchdog well beyond the few hundred cycles of the tests
  initial begin
    #200000;
    n_fail++;
    final_report();
  end

  initial begin
    {i_wr, i_rd, i_t0, i_t1, i_uart, i_can, i_adc, i_wrap, i_idle, i_dma, take, done} = '0;
    {i_addr, i_wdata, i_cap, i_cpin, i_cmp} = '0;
    {i_p0_n, i_p1_n} = 2'b11;
    i_rst_n = 1'b0;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    // reset values, unused bit and unmapped place
    rd(ADDR_SRC_EN_LO, rv); `CHK(rv, 8'h00)
    rd(ADDR_SRC_EN_HI, rv); `CHK(rv, 8'h00)
    wr(ADDR_PRIO_LO, 8'hff); rd(ADDR_PRIO_LO, rv); `CHK(rv, 8'h7f)
    wr(8'h10, 8'h5a); rd(8'h10, rv); `CHK(rv, 8'h00)
    wr(ADDR_PRIO_LO, 8'h00);
    // individual and global masking
    put(15'h7fff);
    wr(ADDR_SRC_EN_LO, 8'h7f); wr(ADDR_SRC_EN_HI, 8'hff); cyc(3);
    `CHK(o_irq, 1'b0)
    wr(ADDR_SRC_EN_LO, 8'h80); wr(ADDR_SRC_EN_HI, 8'h00); cyc(3);
    `CHK(o_irq, 1'b0)
    // fixed rank among equal levels
    wr(ADDR_SRC_EN_LO, 8'hff); wr(ADDR_SRC_EN_HI, 8'hff);
    for (int k = 0; k < 15; k++) begin
      logic [14:0] m;
      m = 15'h7fff;
      for (int j = 0; j < k; j++) m[rank[j]] = 1'b0;
      put(m); cyc(3);
      `CHK(o_src, rank[k][3:0])
    end
    // one vector per source, eight apart
    for (int i = 0; i < 15; i++) begin
      put(15'h0001 << i); cyc(1);
      wait_irq(i);
      `CHK(o_vector, 16'h0003 + 16'(8 * i))
    end
    // high level wins over rank
    wr(ADDR_PRIO_LO, 8'h10); put(15'h0011); cyc(3);
    `CHK({o_level, o_src}, 5'h14)
    wr(ADDR_PRIO_HI, 8'h80); put(15'h4001); cyc(3);
    `CHK({o_level, o_src}, 5'h1e)
    wr(ADDR_PRIO_HI, 8'h00);
    // dma transfer holds all offers off
    @(posedge i_clk) i_dma <= 1'b1;
    cyc(2); `CHK(o_irq, 1'b0)
    @(posedge i_clk) i_dma <= 1'b0;
    wait_irq(0);
    // nesting: low routine, high preempts, high never preempted
    put(15'h0002); cyc(1); take_one(1); cyc(2);
    rd(ADDR_SVC_STAT, rv); `CHK(rv[1:0], 2'b01)
    `CHK(o_irq, 1'b0)
    put(15'h0012); take_one(4); cyc(2);
    rd(ADDR_SVC_STAT, rv); `CHK(rv[1:0], 2'b11)
    put(15'h7fff); cyc(4); `CHK(o_irq, 1'b0)
    put(15'h0001);
    end_svc(8'h01); end_svc(8'h00);
    wait_irq(0);
    // falling edge mode on pin zero
    put(15'h0000); wr(ADDR_TRIG_MODE, 8'h03); cyc(2);
    put(15'h0001); put(15'h0000);
    wait_irq(0);
    take_one(0); end_svc(8'h00); cyc(3);
    `CHK(o_irq, 1'b0)
    // falling edge mode on pin one
    put(15'h0004); put(15'h0000);
    wait_irq(2);
    take_one(2); end_svc(8'h00); cyc(3);
    `CHK(o_irq, 1'b0)
    // capture pin rising edge, ignored while idle
    wr(ADDR_SRC_EN_HI, 8'h01); wr(ADDR_CAP_EDGE, 8'h01);
    @(posedge i_clk) i_cpin <= 4'h1;
    wait_irq(6);
    take_one(6); end_svc(8'h00);
    @(posedge i_clk) i_idle <= 1'b1;
    @(posedge i_clk) i_cpin <= 4'h0;
    @(posedge i_clk) i_cpin <= 4'h1;
    cyc(4); `CHK(o_irq, 1'b0)
    // capture pin falling edge once awake again
    @(posedge i_clk) i_idle <= 1'b0;
    wr(ADDR_CAP_EDGE, 8'h02);
    @(posedge i_clk) i_cpin <= 4'h0;
    wait_irq(6);
    take_one(6); end_svc(8'h00);
    final_report();
  end
endmodule : two_level_interrupt_controller_test
`default_nettype wire
